// *** logic/ebm_top.sv ***
// Endpoint buffer manager: two USB memory pages shared by CPU and USB core
`timescale 1ns/1ps
// Functional notes
// RL1 - Single mode shares one page, 0 or 1, with no back-to-back transfers
// RL2 - USB write counts bytes; good end sets usb done and loads length
// RL3 - CPU reading the last byte sets cpu done; USB may write again
// RL4 - Host frames last 1 ms, each opened by a start-of-frame token
// RL5 - Single IN buffer full at packet limit or when done is set
// RL6 - Frame start with full buffer: USB reads it, then usb done set
// RL7 - CPU write reaching packet limit sets cpu done, buffer full
// RL8 - Done declares single buffer full before the limit
// RL9 - With frame release, each frame start sets cpu done; code sets it only for IN with the CPU buffer not full
// RL10 - Dual mode swaps pages automatically; software cannot pick
// RL11 - CPU buffer full and USB empty: swap and set usb full
// RL12 - USB read end clears usb full; CPU writes continue meanwhile
// RL13 - Done swaps without changing limit; length is bytes written
// RL14 - Dual frame release tags CPU buffer valid, swaps if USB empty
// RL15 - Both full: no swap; USB read end swaps and sets usb done
// RL16 - Sequential access bumps offset; old value is the byte count
// RL17 - Offset reaching length marks CPU buffer full or empty
// RL18 - Done on reads clears cpu full and swaps if usb full
// RL19 - Done after writes: random keeps length, sequential loads offset
// RL20 - Frame start release enabled per endpoint by software
// RL21 - Non-isochronous: NAK when no buffer ready, ACK otherwise
// RL22 - Isochronous IN sends zero-length; OUT without room discards
// RL23 - Auto increment advances the offset on each data access
// RL24 - Random access: write offset, then use the data port
// RL25 - Full flags readable beside the done flags
module ebm_top (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ebm_pkg::ebm_usb_req_t usb_req_i,
  output ebm_pkg::ebm_usb_rsp_t usb_rsp_o
);
  // Address decode, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  logic [7:0] mem_ff [2][ebm_pkg::PAGE_BYTES];
  logic [5:0] ctrl_ff;
  logic [7:0] limit_ff;
  logic [7:0] len_ff;
  logic [7:0] ulen_ff;
  logic [6:0] off_ff;
  logic [6:0] uptr_ff;
  logic cbf_ff;
  logic ubf_ff;
  logic sod_ff;
  logic eod_ff;
  logic cpage_ff;
  logic [31:0] prdata_ff;
  ebm_pkg::ebm_usb_rsp_t rsp_ff;

  logic dual, inc, sofr, dir_in, iso;
  logic cpu_pg, usb_pg;
  logic acc, wr_acc, rd_acc, mapped;
  logic cpu_wr, cpu_rd, done_ev, clr_usb, clr_cpu;
  logic [7:0] off_nx;
  logic fill, fill_lim, drain, in_rdy, out_room, usb_ok, usb_end;
  logic set_sod, set_eod, swap_in_fill, swap_out_ok, swap_drain, swap_end;

  assign dual = ctrl_ff[ebm_pkg::B_DUAL];
  assign inc = ctrl_ff[ebm_pkg::B_INC];
  assign sofr = ctrl_ff[ebm_pkg::B_SOFR];
  assign dir_in = ctrl_ff[ebm_pkg::B_DIRIN];
  assign iso = ctrl_ff[ebm_pkg::B_ISO];

  // Page steering: shared page in single mode, opposite pages in dual
  assign cpu_pg = dual ? cpage_ff : ctrl_ff[ebm_pkg::B_PAGE]; // [RL1] [RL10]
  assign usb_pg = dual ? ~cpage_ff : ctrl_ff[ebm_pkg::B_PAGE]; // [RL1] [RL10]

  // Bus qualifiers; zero wait states
  assign acc = psel_i & penable_i;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & ~pwrite_i;
  assign mapped = hit(paddr_i, ebm_pkg::OFF_CTRL) | hit(paddr_i, ebm_pkg::OFF_STAT)
    | hit(paddr_i, ebm_pkg::OFF_PTR) | hit(paddr_i, ebm_pkg::OFF_LEN)
    | hit(paddr_i, ebm_pkg::OFF_LIM) | hit(paddr_i, ebm_pkg::OFF_DATA);
  assign pready_o = acc;
  assign pslverr_o = acc & ~mapped;
  assign prdata_o = prdata_ff;

  // CPU side events
  assign cpu_wr = wr_acc & hit(paddr_i, ebm_pkg::OFF_DATA) & dir_in; // [RL24]
  assign cpu_rd = rd_acc & hit(paddr_i, ebm_pkg::OFF_DATA) & ~dir_in; // [RL24]
  assign done_ev = wr_acc & hit(paddr_i, ebm_pkg::OFF_STAT) & pwdata_i[ebm_pkg::B_DONE];
  assign clr_usb = wr_acc & hit(paddr_i, ebm_pkg::OFF_STAT) & pwdata_i[ebm_pkg::B_USBDONE];
  assign clr_cpu = wr_acc & hit(paddr_i, ebm_pkg::OFF_STAT) & pwdata_i[ebm_pkg::B_CPUDONE];
  assign off_nx = {1'b0, off_ff} + 8'h01;

  // IN direction: CPU fills, USB drains
  assign fill_lim = cpu_wr & inc & (off_nx == limit_ff); // [RL7] [RL5]
  assign fill = dir_in & ~cbf_ff
    & (fill_lim | done_ev | (usb_req_i.sof & sofr)); // [RL5] [RL8] [RL9] [RL14] [RL20]
  assign in_rdy = dual ? ubf_ff : cbf_ff;
  assign usb_end = dir_in & usb_req_i.rd_done;
  assign swap_in_fill = dual & fill & ~ubf_ff; // [RL11]
  assign swap_end = dual & usb_end & (cbf_ff | fill); // [RL15]

  // OUT direction: USB fills, CPU drains
  assign out_room = dual ? ~ubf_ff : ~cbf_ff;
  assign usb_ok = ~dir_in & usb_req_i.wr_ok & out_room;
  assign drain = ~dir_in & cbf_ff
    & ((cpu_rd & inc & (off_nx == len_ff)) | done_ev); // [RL3] [RL17] [RL18]
  assign swap_out_ok = dual & usb_ok & ~cbf_ff;
  assign swap_drain = dual & drain & ubf_ff; // [RL18]

  assign set_sod = usb_end | usb_ok | swap_drain; // [RL2] [RL6] [RL15]
  assign set_eod = fill | drain; // [RL3] [RL7] [RL9]

  // Control and limit registers
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ctrl_ff <= ebm_pkg::RST_CTRL;
      limit_ff <= ebm_pkg::RST_LIM;
    end else if (ce_i && wr_acc) begin
      if (hit(paddr_i, ebm_pkg::OFF_CTRL)) ctrl_ff <= pwdata_i[5:0]; // [RL20]
      if (hit(paddr_i, ebm_pkg::OFF_LIM)) limit_ff <= pwdata_i[7:0];
    end
  end

  // Done flags: clear by writing one, a set in the same cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sod_ff <= 1'b0;
      eod_ff <= 1'b0;
    end else if (ce_i) begin
      if (clr_usb) sod_ff <= 1'b0;
      if (clr_cpu) eod_ff <= 1'b0;
      if (set_sod) sod_ff <= 1'b1; // [RL2] [RL6] [RL15]
      if (set_eod) eod_ff <= 1'b1; // [RL3] [RL7] [RL9]
    end
  end

  // Buffer ownership, full flags, CPU offset and length
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cbf_ff <= 1'b0;
      ubf_ff <= 1'b0;
      cpage_ff <= 1'b0;
      off_ff <= 7'h00;
      len_ff <= ebm_pkg::RST_LEN;
      ulen_ff <= ebm_pkg::RST_LEN;
    end else if (ce_i) begin
      // Offset writes and auto increment
      if (wr_acc && hit(paddr_i, ebm_pkg::OFF_PTR)) off_ff <= pwdata_i[6:0]; // [RL24]
      if ((cpu_wr || cpu_rd) && inc) off_ff <= off_nx[6:0]; // [RL16] [RL23]
      if (wr_acc && hit(paddr_i, ebm_pkg::OFF_LEN)) len_ff <= pwdata_i[7:0];
      // CPU filled its buffer (IN)
      if (fill) begin
        if (fill_lim) len_ff <= off_nx; // [RL16]
        else if (inc) len_ff <= {1'b0, off_ff}; // [RL13] [RL19]
        if (swap_in_fill) begin
          cpage_ff <= ~cpage_ff; // [RL11] [RL14]
          ubf_ff <= 1'b1; // [RL11]
          off_ff <= 7'h00;
        end else begin
          cbf_ff <= 1'b1; // [RL5] [RL15] [RL17]
        end
      end
      // USB finished reading (IN)
      if (usb_end) begin
        if (!dual) begin
          cbf_ff <= 1'b0; // [RL6]
          off_ff <= 7'h00;
        end else if (swap_end) begin
          cpage_ff <= ~cpage_ff; // [RL15]
          cbf_ff <= 1'b0;
          off_ff <= 7'h00;
        end else begin
          ubf_ff <= 1'b0; // [RL12]
        end
      end
      // USB finished a good write (OUT)
      if (usb_ok) begin
        if (!dual) begin
          cbf_ff <= 1'b1;
          len_ff <= {1'b0, uptr_ff}; // [RL2]
          off_ff <= 7'h00;
        end else if (swap_out_ok) begin
          cpage_ff <= ~cpage_ff;
          cbf_ff <= 1'b1;
          len_ff <= {1'b0, uptr_ff}; // [RL2]
          off_ff <= 7'h00;
        end else begin
          ubf_ff <= 1'b1;
          ulen_ff <= {1'b0, uptr_ff};
        end
      end
      // CPU emptied its buffer (OUT)
      if (drain) begin
        off_ff <= 7'h00;
        if (swap_drain) begin
          cpage_ff <= ~cpage_ff; // [RL18]
          ubf_ff <= 1'b0;
          len_ff <= ulen_ff; // [RL18]
        end else begin
          cbf_ff <= 1'b0; // [RL3] [RL17] [RL18]
        end
      end
    end
  end

  // USB byte pointer: counts bytes, restarts per packet and frame
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      uptr_ff <= 7'h00;
    end else if (ce_i) begin
      if (usb_req_i.sof || usb_req_i.wr_ok || usb_req_i.rd_done) uptr_ff <= 7'h00;
      else if ((usb_req_i.wr && out_room && !dir_in) || usb_req_i.rd)
        uptr_ff <= uptr_ff + 7'h01; // [RL2]
    end
  end

  // Buffer memory; USB writes only land when a page has room
  always_ff @(posedge sys_clk_i) begin
    if (ce_i) begin
      if (cpu_wr) mem_ff[cpu_pg][off_ff] <= pwdata_i[7:0];
      if (usb_req_i.wr && out_room && !dir_in)
        mem_ff[usb_pg][uptr_ff] <= usb_req_i.wdata; // [RL22]
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      prdata_ff <= 32'h0000_0000;
    end else if (ce_i && psel_i && !penable_i) begin
      prdata_ff <= 32'h0000_0000;
      if (hit(paddr_i, ebm_pkg::OFF_CTRL)) prdata_ff[5:0] <= ctrl_ff;
      if (hit(paddr_i, ebm_pkg::OFF_STAT))
        prdata_ff[5:0] <= {cpage_ff, 1'b0, ubf_ff, cbf_ff, eod_ff, sod_ff}; // [RL25]
      if (hit(paddr_i, ebm_pkg::OFF_PTR)) prdata_ff[6:0] <= off_ff;
      if (hit(paddr_i, ebm_pkg::OFF_LEN)) prdata_ff[7:0] <= len_ff;
      if (hit(paddr_i, ebm_pkg::OFF_LIM)) prdata_ff[7:0] <= limit_ff;
      if (hit(paddr_i, ebm_pkg::OFF_DATA)) prdata_ff[7:0] <= mem_ff[cpu_pg][off_ff];
    end
  end

  // Token answers and read data towards the USB core
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      rsp_ff <= '0;
    end else if (ce_i) begin
      rsp_ff.ack <= (usb_req_i.in_tok & dir_in & in_rdy)
        | (usb_req_i.out_tok & ~dir_in & out_room); // [RL21]
      rsp_ff.nak <= ~iso & ((usb_req_i.in_tok & dir_in & ~in_rdy)
        | (usb_req_i.out_tok & ~dir_in & ~out_room)); // [RL21]
      rsp_ff.zlp <= iso & usb_req_i.in_tok & dir_in & ~in_rdy; // [RL22]
      rsp_ff.drop <= iso & usb_req_i.out_tok & ~dir_in & ~out_room; // [RL22]
      if (usb_req_i.rd) rsp_ff.rdata <= mem_ff[usb_pg][uptr_ff];
      rsp_ff.len <= len_ff;
    end
  end
  assign usb_rsp_o = rsp_ff;

  // Checks
  fill_sets_eod_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL7]
    (ce_i && fill) |=> eod_ff) else $error("fill did not set cpu done");
  single_full_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL8]
    (ce_i && fill && !dual) |=> cbf_ff && $stable(cpage_ff)) else $error("single not full");
  dual_swap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL11]
    (ce_i && swap_in_fill && !usb_end) |=> ubf_ff && (cpage_ff != $past(cpage_ff)))
    else $error("no swap on fill");
  usb_end_sod_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL6]
    (ce_i && usb_end && !clr_usb) |=> sod_ff) else $error("usb done not set");
  no_swap_full_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL15]
    (ce_i && dir_in && cbf_ff && ubf_ff && !usb_end) |=> $stable(cpage_ff))
    else $error("swap while both full");
  seq_inc_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL16]
    (ce_i && cpu_wr && inc && !fill && !usb_end) |=> off_ff == $past(off_ff) + 7'h01)
    else $error("offset not advanced");
  nak_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL21]
    (ce_i && usb_req_i.in_tok && dir_in && !iso && !in_rdy) |=> rsp_ff.nak && !rsp_ff.ack)
    else $error("no nak when empty");
  zlp_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL22]
    (ce_i && usb_req_i.in_tok && dir_in && iso && !in_rdy) |=> rsp_ff.zlp && !rsp_ff.nak)
    else $error("no zero-length answer");
  out_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
    (ce_i && usb_ok && !dual) |=> len_ff == {1'b0, $past(uptr_ff)})
    else $error("length not loaded");

  // Shared page in single mode
  single_page_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL1]
    !dual |-> cpu_pg == usb_pg)
    else $error("single mode pages differ");
  // Opposite pages in dual mode
  dual_page_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL10]
    dual |-> cpu_pg != usb_pg)
    else $error("dual mode pages shared");
  // Good USB write raises usb done
  usb_ok_sod_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
    (ce_i && usb_ok) |=> sod_ff)
    else $error("good write left usb done low");
  // Frame start restarts the USB byte pointer
  uptr_rst_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
    (ce_i && usb_req_i.sof) |=> uptr_ff == 7'h00)
    else $error("byte pointer not restarted");
  // Usb done clears when written one with no set
  sod_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL2]
    (ce_i && clr_usb && !set_sod) |=> !sod_ff)
    else $error("usb done not cleared");
  // Cpu done clears when written one with no set
  eod_clear_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL3]
    (ce_i && clr_cpu && !set_eod) |=> !eod_ff)
    else $error("cpu done not cleared");
  // CPU emptying its buffer raises cpu done
  drain_eod_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL3]
    (ce_i && drain) |=> eod_ff)
    else $error("drain left cpu done low");
  // Single buffer is free again after the CPU empties it
  drain_empty_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL3]
    (ce_i && drain && !dual) |=> !cbf_ff)
    else $error("single buffer still full");
  // Done declares a single IN buffer full
  done_full_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL8]
    (ce_i && done_ev && dir_in && !dual && !cbf_ff && !usb_end) |=> cbf_ff)
    else $error("done did not fill buffer");
  // Frame start with release enabled raises cpu done
  sof_release_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL9]
    (ce_i && usb_req_i.sof && sofr && dir_in && !cbf_ff) |=> eod_ff)
    else $error("frame start did not release");
  // USB read end with nothing waiting frees the USB buffer
  usb_end_clr_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL12]
    (ce_i && usb_end && dual && !cbf_ff && !fill) |=> !ubf_ff)
    else $error("usb full not cleared");
  // Done leaves the packet limit alone
  limit_kept_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL13]
    (ce_i && done_ev) |=> limit_ff == $past(limit_ff))
    else $error("limit changed by done");
  // Frame release in dual mode swaps into an empty USB buffer
  sof_swap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL14]
    (ce_i && dual && dir_in && sofr && usb_req_i.sof && !cbf_ff && !ubf_ff && !usb_end)
    |=> ubf_ff && (cpage_ff != $past(cpage_ff))) else $error("no swap on frame start");
  // Limit reached loads the byte count
  lim_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL16]
    (ce_i && fill_lim) |=> len_ff == $past(off_nx))
    else $error("limit length not loaded");
  // Done after reads swaps in a waiting USB buffer
  drain_swap_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL18]
    (ce_i && swap_drain) |=> !ubf_ff && (cpage_ff != $past(cpage_ff)))
    else $error("no swap on drain");
  // Swapped-in buffer brings its received count
  drain_len_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL18]
    (ce_i && swap_drain) |=> len_ff == $past(ulen_ff))
    else $error("received count lost");
  // Sequential done loads the offset as length
  done_len_seq_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL19]
    (ce_i && fill && done_ev && inc) |=> len_ff == {1'b0, $past(off_ff)})
    else $error("sequential length wrong");
  // Random access done keeps the length
  done_len_rand_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL19]
    (ce_i && fill && !inc) |=> $stable(len_ff))
    else $error("random length changed");
  // Ready IN buffer answers with ack
  in_ack_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL21]
    (ce_i && usb_req_i.in_tok && dir_in && in_rdy) |=> rsp_ff.ack && !rsp_ff.zlp)
    else $error("no ack when ready");
  // OUT token with room answers with ack
  out_ack_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL21]
    (ce_i && usb_req_i.out_tok && !dir_in && out_room) |=> rsp_ff.ack && !rsp_ff.nak)
    else $error("no ack with room");
  // Isochronous OUT with no room is dropped
  iso_drop_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL22]
    (ce_i && usb_req_i.out_tok && !dir_in && iso && !out_room) |=> rsp_ff.drop && !rsp_ff.nak)
    else $error("no drop when full");
  // Offset write lands when no event moves the offset
  ptr_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL24]
    (ce_i && wr_acc && hit(paddr_i, ebm_pkg::OFF_PTR) && !usb_req_i.sof && !usb_end && !usb_ok)
    |=> off_ff == $past(pwdata_i[6:0])) else $error("offset write lost");
  // Status read shows both full flags
  stat_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL25]
    (ce_i && psel_i && !penable_i && hit(paddr_i, ebm_pkg::OFF_STAT))
    |=> prdata_ff[2] == $past(cbf_ff) && prdata_ff[3] == $past(ubf_ff))
    else $error("full flags not shown");
  // Clock enable low freezes buffer ownership
  freeze_a: assert property (@(posedge sys_clk_i) disable iff (srst_i) // [RL10]
    !ce_i |=> $stable(cbf_ff) && $stable(ubf_ff) && $stable(cpage_ff))
    else $error("state moved while frozen");
endmodule : ebm_top

// *** logic/ebm_pkg.sv ***
// Package for the endpoint buffer manager: offsets, fields, reset values, carriers
package ebm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_LEN = 8'h0c;
  localparam logic [7:0] OFF_LIM = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  // Control field positions
  localparam int B_DUAL = 0;
  localparam int B_PAGE = 1;
  localparam int B_INC = 2;
  localparam int B_SOFR = 3;
  localparam int B_DIRIN = 4;
  localparam int B_ISO = 5;
  // Status field positions
  localparam int B_USBDONE = 0;
  localparam int B_CPUDONE = 1;
  localparam int B_CBF = 2;
  localparam int B_UBF = 3;
  localparam int B_DONE = 4;
  localparam int B_CPAGE = 5;
  // Reset values
  localparam logic [5:0] RST_CTRL = 6'h00;
  localparam logic [7:0] RST_LEN = 8'h00;
  localparam logic [7:0] RST_LIM = 8'h40;
  localparam int PAGE_BYTES = 128;
  // Strobes from the USB protocol core, all one-cycle pulses
  typedef struct packed {
    logic sof;
    logic wr;
    logic wr_ok;
    logic rd;
    logic rd_done;
    logic in_tok;
    logic out_tok;
    logic [7:0] wdata;
  } ebm_usb_req_t;
  // Answers to the USB protocol core
  typedef struct packed {
    logic ack;
    logic nak;
    logic zlp;
    logic drop;
    logic [7:0] rdata;
    logic [7:0] len;
  } ebm_usb_rsp_t;
endpackage : ebm_pkg

// *** verif/ebm_usb_model.sv ***
// Behavioural model of the USB protocol core facing the buffer manager
`timescale 1ns/1ps
module ebm_usb_model (
  input wire logic sys_clk_i,
  output ebm_pkg::ebm_usb_req_t usb_req_o,
  input wire ebm_pkg::ebm_usb_rsp_t usb_rsp_i
);
  // All strobes idle from time zero
  initial begin
    usb_req_o = '0;
  end
  // One strobe for one cycle; the answer is taken one cycle after it
  task automatic pulse(input logic [6:0] s, input logic [7:0] d,
      output ebm_pkg::ebm_usb_rsp_t rsp);
    @(posedge sys_clk_i);
    usb_req_o <= {s, d};
    @(posedge sys_clk_i);
    usb_req_o <= {7'h00, ~d}; // Released data line shows the inverse
    @(posedge sys_clk_i);
    rsp = usb_rsp_i;
  endtask : pulse
endmodule : ebm_usb_model

// *** verif/ebm_top_tb.sv ***
// Self-checking bench for the endpoint buffer manager
`timescale 1ns/1ps
module ebm_top_tb;
  localparam logic [6:0] SOF = 7'h40, WR = 7'h20, WOK = 7'h10, RD = 7'h08;
  localparam logic [6:0] RDN = 7'h04, TIN = 7'h02, TOUT = 7'h01;
  logic ce = 1'b1;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, slv;
  ebm_pkg::ebm_usb_req_t usb_req;
  ebm_pkg::ebm_usb_rsp_t usb_rsp, r;
  int n_mismatch = 0;
  int num_checks = 0;
  // 25 MHz clock
  always #20 sys_clk_i = ~sys_clk_i;
  ebm_top i_ebm_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .usb_req_i(usb_req),
    .usb_rsp_o(usb_rsp));
  ebm_usb_model i_ebm_usb_model (.sys_clk_i(sys_clk_i), .usb_req_o(usb_req),
    .usb_rsp_i(usb_rsp));
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Closing report
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      chk("pready wait", 32'h1, 32'h0);
      give_verdict();
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  // Read a register and compare the masked bits
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), e, q & m);
  endtask : rdc
  // Reset values and an unmapped address
  task automatic s_reset();
    rdc(ebm_pkg::OFF_LIM, 32'hff, 32'h40);
    rdc(ebm_pkg::OFF_CTRL, 32'h3f, 32'h00);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, slv});
  endtask : s_reset
  // Single buffer IN: fill to the limit, USB drains, then empty answers
  task automatic s_single_in();
    wr(ebm_pkg::OFF_CTRL, 32'h14);
    wr(ebm_pkg::OFF_LIM, 32'h4);
    wr(ebm_pkg::OFF_STAT, 32'h3);
    wr(ebm_pkg::OFF_PTR, 32'h0);
    for (int i = 0; i < 4; i++) wr(ebm_pkg::OFF_DATA, 32'ha0 + i);
    rdc(ebm_pkg::OFF_STAT, 32'h0e, 32'h06);
    i_ebm_usb_model.pulse(SOF, 8'h00, r);
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    chk("ack", 32'h1, {31'h0, r.ack});
    for (int i = 0; i < 4; i++) begin
      i_ebm_usb_model.pulse(RD, 8'h00, r);
      chk("usb read byte", 32'ha0 + i, {24'h0, r.rdata});
    end
    i_ebm_usb_model.pulse(RDN, 8'h00, r);
    rdc(ebm_pkg::OFF_STAT, 32'h05, 32'h01);
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    chk("nak", 32'h1, {31'h0, r.nak});
    wr(ebm_pkg::OFF_CTRL, 32'h34);
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    chk("zero length", 32'h1, {31'h0, r.zlp});
  endtask : s_single_in
  // Single IN with frame release: one byte, frame start hands it over
  task automatic s_sof();
    wr(ebm_pkg::OFF_CTRL, 32'h1c);
    wr(ebm_pkg::OFF_STAT, 32'h3);
    wr(ebm_pkg::OFF_PTR, 32'h0);
    wr(ebm_pkg::OFF_DATA, 32'h77);
    i_ebm_usb_model.pulse(SOF, 8'h00, r);
    rdc(ebm_pkg::OFF_STAT, 32'h06, 32'h06);
    rdc(ebm_pkg::OFF_LEN, 32'hff, 32'h01);
    i_ebm_usb_model.pulse(RDN, 8'h00, r);
    rdc(ebm_pkg::OFF_STAT, 32'h04, 32'h00);
  endtask : s_sof
  // Single buffer OUT: USB writes three bytes, CPU reads them back
  task automatic s_single_out();
    wr(ebm_pkg::OFF_CTRL, 32'h04);
    wr(ebm_pkg::OFF_STAT, 32'h3);
    for (int i = 0; i < 3; i++) i_ebm_usb_model.pulse(WR, 8'h50 + i, r);
    i_ebm_usb_model.pulse(WOK, 8'h00, r);
    rdc(ebm_pkg::OFF_LEN, 32'hff, 32'h3);
    rdc(ebm_pkg::OFF_STAT, 32'h01, 32'h01);
    i_ebm_usb_model.pulse(TOUT, 8'h00, r);
    chk("out nak when full", 32'h1, {31'h0, r.nak});
    wr(ebm_pkg::OFF_PTR, 32'h0);
    for (int i = 0; i < 3; i++) rdc(ebm_pkg::OFF_DATA, 32'hff, 32'h50 + i);
    rdc(ebm_pkg::OFF_STAT, 32'h06, 32'h02);
  endtask : s_single_out
  // Dual IN: swap at the limit, done with both full, swap after USB read
  task automatic s_dual();
    wr(ebm_pkg::OFF_CTRL, 32'h15);
    wr(ebm_pkg::OFF_LIM, 32'h2);
    wr(ebm_pkg::OFF_PTR, 32'h0);
    wr(ebm_pkg::OFF_STAT, 32'h3);
    for (int i = 0; i < 2; i++) wr(ebm_pkg::OFF_DATA, 32'hc0 + i);
    rdc(ebm_pkg::OFF_STAT, 32'h0c, 32'h08);
    wr(ebm_pkg::OFF_DATA, 32'hd0);
    wr(ebm_pkg::OFF_STAT, 32'h10);
    rdc(ebm_pkg::OFF_STAT, 32'h0c, 32'h0c);
    rdc(ebm_pkg::OFF_LIM, 32'hff, 32'h02);
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    for (int i = 0; i < 2; i++) begin
      i_ebm_usb_model.pulse(RD, 8'h00, r);
      chk("dual read byte", 32'hc0 + i, {24'h0, r.rdata});
    end
    i_ebm_usb_model.pulse(RDN, 8'h00, r);
    rdc(ebm_pkg::OFF_STAT, 32'h0d, 32'h09);
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    i_ebm_usb_model.pulse(RD, 8'h00, r);
    chk("second packet byte", 32'hd0, {24'h0, r.rdata});
    ce <= 1'b0;
    i_ebm_usb_model.pulse(TIN, 8'h00, r);
    chk("frozen ack", 32'h0, {31'h0, r.ack});
    ce <= 1'b1;
  endtask : s_dual
  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    s_reset();
    s_single_in();
    s_sof();
    s_single_out();
    s_dual();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    chk("run time", 32'h1, 32'h0);
    give_verdict();
  end
endmodule : ebm_top_tb
